// ===== core/pstg_defines.vh
// Constants for the PWM-synchronised ADC trigger generator.
// Assumes a 32-bit APB register bus and a 16-bit carrier counter.
`ifndef PSTG_DEFINES_VH
`define PSTG_DEFINES_VH

// Register byte addresses
`define PSTG_ADDR_MODE 32'hffffc324
`define PSTG_ADDR_CMP0 32'hffffc328
`define PSTG_ADDR_CMP1 32'hffffc32c
`define PSTG_ADDR_CMP2 32'hffffc330
`define PSTG_ADDR_STAT 32'hffffc334
`define PSTG_ADDR_TCNT 32'hffffc338

// Widths
`define PSTG_CW 16
`define PSTG_MW 3
`define PSTG_NCH 3

// Reset values
`define PSTG_MODE_RST 9'h000
`define PSTG_CMP_RST 16'h0000
`define PSTG_CNT_RST 8'h00

// Mode register field positions (low bit of each three-bit field)
`define PSTG_MODE_LSB0 0
`define PSTG_MODE_LSB1 3
`define PSTG_MODE_LSB2 6
`define PSTG_MODE_FW 9

// Trigger mode codes
`define PSTG_MD_OFF 3'h0
`define PSTG_MD_DOWN 3'h1
`define PSTG_MD_UP 3'h2
`define PSTG_MD_BOTH 3'h3
`define PSTG_MD_PEAK 3'h4
`define PSTG_MD_BOTTOM 3'h5
`define PSTG_MD_EXTREME 3'h6
`define PSTG_MD_RSVD 3'h7

// Status register bit positions
`define PSTG_ST_EN 0
`define PSTG_ST_EMG 1
`define PSTG_ST_EDGE 2
`define PSTG_ST_UP 3
`define PSTG_ST_TRG 4

// Trigger count register field width
`define PSTG_TCW 8
`define PSTG_ZERO16 16'h0000

`endif

// ===== core/pstg_carrier_track.v
// Carrier edge tracker: detects a new counter value, its slope and the extremes.
// Assumes the carrier counter runs on pclk; it may hold a value for many cycles.
`timescale 1ns/1ps
`include "pstg_defines.vh"

module pstg_carrier_track (
   input wire pclk,
   input wire presetn,
   input wire [15:0] carrier_counter,
   input wire [15:0] carrier_period,
   output wire step,
   output wire counting_up,
   output wire at_peak,
   output wire at_bottom
);

   reg [15:0] prev_q;
   reg seen_q;

   // Previous counter value; a value is an event only on its first cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= `PSTG_ZERO16;
         seen_q <= 1'b0;
      end else begin
         prev_q <= carrier_counter;
         seen_q <= 1'b1;
      end
   end

   // Slope comes from the step itself, so no direction state can go stale
   assign step = seen_q && (carrier_counter != prev_q);
   assign counting_up = carrier_counter > prev_q;
   assign at_peak = step && (carrier_counter == carrier_period);
   assign at_bottom = step && (carrier_counter == `PSTG_ZERO16);

endmodule // pstg_carrier_track

// ===== core/pstg_trig_chan.v
// One trigger channel: double-buffered compare value and mode decode.
// Assumes carrier events from pstg_carrier_track on the same clock.
`timescale 1ns/1ps
`include "pstg_defines.vh"

module pstg_trig_chan (
   input wire pclk,
   input wire presetn,
   input wire [2:0] trigger_mode_select,
   input wire [15:0] compare_holding_buffer,
   input wire [15:0] carrier_counter,
   input wire step,
   input wire counting_up,
   input wire at_peak,
   input wire at_bottom,
   input wire edge_mode,
   input wire load_now,
   output wire hit
);

   reg [15:0] active_q;
   reg load;
   reg fire;
   wire match;

   assign match = step && (carrier_counter == active_q);

   // Update point per mode; peak/bottom modes reload only on load_now
   always @* begin
      load = load_now;
      case (trigger_mode_select)
         `PSTG_MD_DOWN: load = load | at_peak;
         `PSTG_MD_UP: load = load | at_bottom;
         `PSTG_MD_BOTH: load = load | at_peak | at_bottom;
         default: load = load;
      endcase
   end

   // Active compare stage, fed only from the holding stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q <= `PSTG_CMP_RST;
      end else if (load) begin
         active_q <= compare_holding_buffer;
      end
   end

   // Trigger qualification; edge mode only ever counts up
   always @* begin
      case (trigger_mode_select)
         `PSTG_MD_OFF: fire = 1'b0;
         `PSTG_MD_DOWN: fire = match && (edge_mode ? counting_up : !counting_up);
         `PSTG_MD_UP: fire = match && counting_up;
         `PSTG_MD_BOTH: fire = match;
         `PSTG_MD_PEAK: fire = at_peak;
         `PSTG_MD_BOTTOM: fire = at_bottom;
         `PSTG_MD_EXTREME: fire = at_peak | at_bottom;
         default: fire = 1'b0;
      endcase
   end

   assign hit = fire;

endmodule // pstg_trig_chan

// ===== core/pstg_top.v
// ADC trigger generator synchronised to the PWM carrier, with its APB registers.
// Assumes carrier counter, period, enable, edge-mode and protection inputs come
// from PWM logic on pclk, so they are used without synchronisers.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pstg_defines.vh"

module pstg_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [15:0] carrier_counter,
   input wire [15:0] carrier_period,
   input wire pwm_output_enable,
   input wire pwm_edge_mode,
   input wire emergency_protection,
   output reg [2:0] adc_trigger_out
);

   // Register decode, shared by the read mux and the error check
   function [2:0] reg_sel;
      input [31:0] a;
      begin
         case (a)
            `PSTG_ADDR_MODE: reg_sel = 3'h1;
            `PSTG_ADDR_CMP0: reg_sel = 3'h2;
            `PSTG_ADDR_CMP1: reg_sel = 3'h3;
            `PSTG_ADDR_CMP2: reg_sel = 3'h4;
            `PSTG_ADDR_STAT: reg_sel = 3'h5;
            `PSTG_ADDR_TCNT: reg_sel = 3'h6;
            default: reg_sel = 3'h0;
         endcase
      end
   endfunction

   // Byte-lane merge for the 16-bit registers; lanes 2 and 3 carry nothing
   function [15:0] lane_merge;
      input [15:0] old_v;
      input [15:0] new_v;
      input [1:0] lanes;
      begin
         lane_merge = old_v;
         if (lanes[0]) begin
            lane_merge[7:0] = new_v[7:0];
         end
         if (lanes[1]) begin
            lane_merge[15:8] = new_v[15:8];
         end
      end
   endfunction

   localparam [2:0] SEL_NONE = 3'h0;
   localparam [2:0] SEL_MODE = 3'h1;
   localparam [2:0] SEL_CMP0 = 3'h2;
   localparam [2:0] SEL_CMP1 = 3'h3;
   localparam [2:0] SEL_CMP2 = 3'h4;
   localparam [2:0] SEL_STAT = 3'h5;
   localparam [2:0] SEL_TCNT = 3'h6;

   // Unmapped addresses and writes to the read-only status answer with an error
   function refused;
      input [2:0] s;
      input w;
      begin
         refused = (s == SEL_NONE) || (w && (s == SEL_STAT));
      end
   endfunction

   // APB slave states: idle, then one answered access cycle
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ANSWER = 2'h1;

   reg [1:0] state_q;
   reg [8:0] mode_q;
   reg [15:0] hold_q [0:2];
   reg [7:0] tcnt_q [0:2];
   reg [2:0] last_trg_q;
   reg [31:0] rdata_d;

   wire [2:0] sel;
   wire setup;
   wire wr_done;
   wire step;
   wire counting_up;
   wire at_peak;
   wire at_bottom;
   wire gate_open;
   wire [2:0] hit;
   wire [2:0] trig_d;
   wire [2:0] cmp_wr;
   wire cnt_clr;
   wire [15:0] mode_wr;

   assign sel = reg_sel(paddr);
   assign setup = psel && !penable;
   // A write lands only at the edge where the access phase meets pready
   // Refused writes never land, whatever the decode says
   assign wr_done = psel && penable && pready && pwrite && !refused(sel, pwrite);
   assign cnt_clr = wr_done && (sel == SEL_TCNT);
   assign cmp_wr[0] = wr_done && (sel == SEL_CMP0);
   assign cmp_wr[1] = wr_done && (sel == SEL_CMP1);
   assign cmp_wr[2] = wr_done && (sel == SEL_CMP2);

   // Both gates act on all channels at once, whatever the modes say
   assign gate_open = pwm_output_enable && !emergency_protection;

   // Carrier step, slope and extreme detection
   pstg_carrier_track u_track (
      .pclk(pclk),
      .presetn(presetn),
      .carrier_counter(carrier_counter),
      .carrier_period(carrier_period),
      .step(step),
      .counting_up(counting_up),
      .at_peak(at_peak),
      .at_bottom(at_bottom)
   );

   // One channel per trigger output
   genvar gi;
   generate
      for (gi = 0; gi < `PSTG_NCH; gi = gi + 1) begin : g_chan
         pstg_trig_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .trigger_mode_select(mode_q[gi*`PSTG_MW +: `PSTG_MW]),
            .compare_holding_buffer(hold_q[gi]),
            .carrier_counter(carrier_counter),
            .step(step),
            .counting_up(counting_up),
            .at_peak(at_peak),
            .at_bottom(at_bottom),
            .edge_mode(pwm_edge_mode),
            // While PWM is stopped nothing is timed off the carrier, so the
            // active stage simply follows the holding stage
            .load_now(!pwm_output_enable),
            .hit(hit[gi])
         );
      end
   endgenerate

   // Gate after the decode, so a closed gate drops peak and bottom triggers too
   assign trig_d = gate_open ? hit : 3'h0;

   // Trigger outputs registered; a hit exists only on a step's first cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_trigger_out <= 3'h0;
         last_trg_q <= 3'h0;
      end else begin
         adc_trigger_out <= trig_d;
         if (trig_d != 3'h0) begin
            last_trg_q <= trig_d;
         end
      end
   end

   // Mode register; ordering against PWM enable is left to software
   assign mode_wr = lane_merge({7'h00, mode_q}, pwdata[15:0], pstrb[1:0]);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `PSTG_MODE_RST;
      end else if (wr_done && (sel == SEL_MODE)) begin
         mode_q <= mode_wr[`PSTG_MODE_FW-1:0];
      end
   end

   // Compare holding stages, one per channel, byte-lane writable
   genvar gh;
   generate
      for (gh = 0; gh < `PSTG_NCH; gh = gh + 1) begin : g_hold
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hold_q[gh] <= `PSTG_CMP_RST;
            end else if (cmp_wr[gh]) begin
               // Range against the period is not checked here
               hold_q[gh] <= lane_merge(hold_q[gh], pwdata[15:0], pstrb[1:0]);
            end
         end
      end
   endgenerate

   // Counter next value; a trigger in the clearing cycle still counts once
   function [7:0] cnt_next;
      input [7:0] cur;
      input clr;
      input trg;
      begin
         if (clr) begin
            cnt_next = {7'h00, trg};
         end else if (trg) begin
            cnt_next = cur + 8'h01;
         end else begin
            cnt_next = cur;
         end
      end
   endfunction

   // Trigger counters, one per channel, wrapping at eight bits
   genvar gc;
   generate
      for (gc = 0; gc < `PSTG_NCH; gc = gc + 1) begin : g_tcnt
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tcnt_q[gc] <= `PSTG_CNT_RST;
            end else begin
               tcnt_q[gc] <= cnt_next(tcnt_q[gc], cnt_clr, trig_d[gc]);
            end
         end
      end
   endgenerate

   // Read mux; reserved bits read as zero
   always @* begin
      rdata_d = 32'h0000_0000;
      case (sel)
         SEL_MODE: rdata_d[`PSTG_MODE_FW-1:0] = mode_q;
         SEL_CMP0: rdata_d[15:0] = hold_q[0];
         SEL_CMP1: rdata_d[15:0] = hold_q[1];
         SEL_CMP2: rdata_d[15:0] = hold_q[2];
         SEL_STAT: begin
            rdata_d[`PSTG_ST_EN] = pwm_output_enable;
            rdata_d[`PSTG_ST_EMG] = emergency_protection;
            rdata_d[`PSTG_ST_EDGE] = pwm_edge_mode;
            rdata_d[`PSTG_ST_UP] = counting_up;
            rdata_d[`PSTG_ST_TRG +: 3] = last_trg_q;
         end
         SEL_TCNT: rdata_d[23:0] = {tcnt_q[2], tcnt_q[1], tcnt_q[0]};
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // APB next state: setup is answered in the very next cycle, no wait states
   reg [1:0] state_d;
   reg pready_d;
   reg pslverr_d;
   reg [31:0] prdata_d;

   always @* begin
      state_d = state_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = prdata;
      case (state_q)
         ST_IDLE: begin
            if (setup) begin
               state_d = ST_ANSWER;
               pready_d = 1'b1;
               pslverr_d = refused(sel, pwrite);
               // Read data is frozen at setup, so it stands through the access
               prdata_d = pwrite ? 32'h0000_0000 : rdata_d;
            end
         end
         ST_ANSWER: begin
            // Back to idle; the next setup may follow straight away
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // APB answer registers; a setup in the cycle right after another setup, where its access phase belongs, is not answered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         prdata <= prdata_d;
      end
   end

endmodule // pstg_top

// ===== verif/pstg_chk.sv
// Checker on the pstg_top ports: APB handshake and trigger pulse relations.
// Assumes one pclk domain and the register map of pstg_defines.vh.
`timescale 1ns/1ps
`include "pstg_defines.vh"
module pstg_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [31:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [15:0] carrier_counter,
   input wire pwm_output_enable,
   input wire emergency_protection,
   input wire [2:0] adc_trigger_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Map is six consecutive words
   wire mapped = paddr >= `PSTG_ADDR_MODE && paddr <= `PSTG_ADDR_TCNT && paddr[1:0] == 2'h0;
   wire setup = psel && !penable;

   a_trig_single: assert property ((adc_trigger_out & $past(adc_trigger_out)) == 3'h0)
      else $error("trigger longer than one cycle");
   a_off_gate: assert property (!pwm_output_enable |=> adc_trigger_out == 3'h0)
      else $error("trigger while output disabled");
   a_emg_gate: assert property (emergency_protection |=> adc_trigger_out == 3'h0)
      else $error("trigger under protection");
   a_trig_on_step: assert property (adc_trigger_out != 3'h0 |-> $past(carrier_counter) != $past(carrier_counter, 2))
      else $error("trigger without a new count");
   a_apb_zero_wait: assert property (setup |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
endmodule // pstg_chk

bind pstg_top pstg_chk pstg_chk_i (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
   .carrier_counter, .pwm_output_enable, .emergency_protection, .adc_trigger_out);

// ===== verif/pstg_carrier_model.sv
// Carrier counter model: triangle, or saw in edge-aligned mode.
// Assumes the bench starts and stops it; the count rests at 0 while stopped.
`timescale 1ns/1ps
module pstg_carrier_model (
   input wire pclk,
   input wire presetn,
   input wire run,
   input wire pwm_edge_mode,
   input wire [15:0] carrier_period,
   input wire [3:0] hold,
   output reg [15:0] carrier_counter
);
   reg up_q;
   reg [3:0] wait_q;
   // Each value stays hold+1 cycles, so slow carriers are covered too
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier_counter <= 16'h0000;
         up_q <= 1'h1;
         wait_q <= 4'h0;
      end else if (!run) begin
         carrier_counter <= 16'h0000;
         up_q <= 1'h1;
         wait_q <= 4'h0;
      end else if (wait_q != hold) begin
         wait_q <= wait_q + 4'h1;
      end else begin
         wait_q <= 4'h0;
         if (pwm_edge_mode) begin
            carrier_counter <= (carrier_counter == carrier_period) ? 16'h0000 : carrier_counter + 16'h0001;
         end else if (up_q) begin
            carrier_counter <= carrier_counter + 16'h0001;
            up_q <= (carrier_counter + 16'h0001) != carrier_period;
         end else begin
            carrier_counter <= carrier_counter - 16'h0001;
            up_q <= carrier_counter == 16'h0001;
         end
      end
   end
endmodule // pstg_carrier_model

// ===== verif/test_pwm_sync_adc_trigger_gen.sv
// Bench for pstg_top: registers over APB, trigger counts per mode.
// Assumes pstg_carrier_model drives the carrier; the checker is bound.
`timescale 1ns/1ps
`include "pstg_defines.vh"
module test_pwm_sync_adc_trigger_gen;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, run;
   logic pwm_output_enable, pwm_edge_mode, emergency_protection;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [15:0] carrier_counter, carrier_period;
   logic [3:0] hold, pstrb;
   logic [2:0] adc_trigger_out;
   int miscompares, checks_done;
   int pulses [3];

   pstg_top pstg_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .carrier_counter, .carrier_period, .pwm_output_enable, .pwm_edge_mode,
      .emergency_protection, .adc_trigger_out);
   pstg_carrier_model pstg_carrier_model_i (.pclk, .presetn, .run, .pwm_edge_mode, .carrier_period, .hold,
      .carrier_counter);

   always #2.5 pclk = ~pclk;

   // Pulses seen on the trigger pins, apart from the design's own counters
   always @(posedge pclk) begin
      for (int c = 0; c < 3; c++) if (adc_trigger_out[c] === 1'h1) pulses[c]++;
   end

   task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One transfer; request held until pready is sampled high
   task automatic apb(input w, input [31:0] a, input [31:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic wcnt(input [15:0] v);
      int n;
      n = 0;
      while (carrier_counter !== v && n < 500) begin
         @(posedge pclk);
         n++;
      end
      chk("carrier value", {16'h0, v}, {16'h0, carrier_counter});
   endtask

   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         apb(1'h0, `PSTG_ADDR_MODE + 4 * i, 32'h0);
         chk("reset value", 32'h0, rd);
      end
      apb(1'h1, `PSTG_ADDR_MODE, 32'hffffffff);
      apb(1'h0, `PSTG_ADDR_MODE, 32'h0);
      chk("mode fields", 32'h1ff, rd);
      apb(1'h1, `PSTG_ADDR_CMP1, 32'h1234abcd);
      apb(1'h0, `PSTG_ADDR_CMP1, 32'h0);
      chk("compare word", 32'habcd, rd);
      apb(1'h0, 32'hffffc340, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'h1, `PSTG_ADDR_STAT, 32'h0);
      chk("status write error", 32'h1, {31'h0, err});
      apb(1'h0, `PSTG_ADDR_STAT, 32'h0);
      chk("status idle", 32'h0, rd);
      apb(1'h1, `PSTG_ADDR_CMP2, 32'hffff);
      pstrb <= 4'h1;
      apb(1'h1, `PSTG_ADDR_CMP2, 32'h0012);
      pstrb <= 4'hf;
      apb(1'h0, `PSTG_ADDR_CMP2, 32'h0);
      chk("byte lane write", 32'hff12, rd);
      $display("register test done");
   endtask

   // Two carrier cycles, then the per-channel pulse counts
   task automatic run_case(input [8:0] md, input en, input em, input ed, input [23:0] exp);
      apb(1'h1, `PSTG_ADDR_MODE, {23'h0, md});
      apb(1'h1, `PSTG_ADDR_TCNT, 32'h0);
      pwm_output_enable <= en;
      emergency_protection <= em;
      pwm_edge_mode <= ed;
      @(posedge pclk);
      apb(1'h0, `PSTG_ADDR_STAT, 32'h0);
      chk("status inputs", {29'h0, ed, em, en}, rd & 32'h7);
      foreach (pulses[c]) pulses[c] = 0;
      run <= 1'h1;
      repeat (2) begin
         wcnt(carrier_period);
         wcnt(16'h0);
      end
      repeat (3) @(posedge pclk);
      {run, pwm_output_enable, emergency_protection, pwm_edge_mode} <= 4'h0;
      apb(1'h0, `PSTG_ADDR_TCNT, 32'h0);
      chk("trigger counts", {8'h0, exp}, rd);
      chk("trigger pulses", {8'h0, exp}, {8'h0, pulses[2][7:0], pulses[1][7:0], pulses[0][7:0]});
      $display("mode case done");
   endtask

   // New compares written mid-cycle must wait for the update point
   task automatic t_dbuf;
      hold <= 4'h3;
      apb(1'h1, `PSTG_ADDR_MODE, 32'h00a);
      apb(1'h1, `PSTG_ADDR_TCNT, 32'h0);
      pwm_output_enable <= 1'h1;
      @(posedge pclk);
      foreach (pulses[c]) pulses[c] = 0;
      run <= 1'h1;
      wcnt(16'h8);
      apb(1'h1, `PSTG_ADDR_CMP0, 32'h9);
      wcnt(carrier_period);
      wcnt(16'h7);
      apb(1'h1, `PSTG_ADDR_CMP1, 32'h9);
      wcnt(16'h0);
      wcnt(carrier_period);
      wcnt(16'h0);
      repeat (3) @(posedge pclk);
      {run, pwm_output_enable} <= 2'h0;
      apb(1'h0, `PSTG_ADDR_TCNT, 32'h0);
      chk("buffered counts", 32'h0202, rd);
      chk("buffered pulses", 32'h0202, {16'h0, pulses[1][7:0], pulses[0][7:0]});
      $display("buffer test done");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      pclk = 1'h0;
      presetn = 1'h0;
      {psel, penable, pwrite, paddr, pwdata, run} = '0;
      {pwm_output_enable, pwm_edge_mode, emergency_protection} = 3'h0;
      carrier_period = 16'hc;
      hold = 4'h1;
      pstrb = 4'hf;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_regs;
      for (int i = 0; i < 3; i++) apb(1'h1, `PSTG_ADDR_CMP0 + 4 * i, 32'h5);
      run_case({3'h3, 3'h2, 3'h1}, 1'h1, 1'h0, 1'h0, 24'h040202);
      run_case({3'h6, 3'h5, 3'h4}, 1'h1, 1'h0, 1'h0, 24'h040202);
      run_case({3'h1, 3'h0, 3'h7}, 1'h1, 1'h0, 1'h0, 24'h020000);
      run_case({3'h3, 3'h3, 3'h3}, 1'h0, 1'h0, 1'h0, 24'h0);
      run_case({3'h3, 3'h3, 3'h3}, 1'h1, 1'h1, 1'h0, 24'h0);
      run_case({3'h3, 3'h2, 3'h1}, 1'h1, 1'h0, 1'h1, 24'h020202);
      t_dbuf;
      test_done;
   end

   // Cut a hang; the tests need well under 3000 cycles
   initial begin
      #50000;
      miscompares++;
      test_done;
   end
endmodule // test_pwm_sync_adc_trigger_gen
